// *** core/rtca_pkg.sv ***
// Purpose: shared constants for the alarm-0 match unit
// Assumes: 32-bit AXI4-Lite register bus, 8-bit registers in the low bits
// Notes: offsets are byte addresses of aligned words
package rtca_pkg;
  // field count and width
  localparam int unsigned RTCA_FIELDS = 6;
  localparam int unsigned RTCA_REG_W = 8;
  // register byte offsets
  localparam logic [7:0] RTCA_OFS_ALM_SEC = 8'h00;
  localparam logic [7:0] RTCA_OFS_ALM_MIN = 8'h04;
  localparam logic [7:0] RTCA_OFS_ALM_HOUR = 8'h08;
  localparam logic [7:0] RTCA_OFS_ALM_DATE = 8'h0C;
  localparam logic [7:0] RTCA_OFS_ALM_MONTH = 8'h10;
  localparam logic [7:0] RTCA_OFS_ALM_WDAY = 8'h14;
  localparam logic [7:0] RTCA_OFS_INT_CTRL = 8'h18;
  localparam logic [7:0] RTCA_OFS_STATUS = 8'h1C;
  localparam logic [7:0] RTCA_OFS_MASK = 8'h20;
  // register indices
  localparam logic [3:0] RTCA_IDX_CTRL = 4'h6;
  localparam logic [3:0] RTCA_IDX_STATUS = 4'h7;
  localparam logic [3:0] RTCA_IDX_MASK = 4'h8;
  localparam logic [3:0] RTCA_IDX_NONE = 4'hF;
  // field positions
  localparam int unsigned RTCA_CMP_EN_BIT = 7;
  localparam int unsigned RTCA_ALM_EN_BIT = 5;
  localparam int unsigned RTCA_PULSED_BIT = 7;
  localparam int unsigned RTCA_FLAG_BIT = 0;
  // reset values
  localparam logic [7:0] RTCA_ALM_RST = 8'h00;
  localparam logic [7:0] RTCA_CTRL_RST = 8'h00;
  localparam logic [7:0] RTCA_STATUS_RST = 8'h00;
  localparam logic [7:0] RTCA_MASK_RST = 8'h00;
  // bus answers
  localparam logic [1:0] RTCA_RESP_OKAY = 2'h0;
  localparam logic [1:0] RTCA_RESP_SLVERR = 2'h2;
endpackage

// *** core/rtca_cmp_if.sv ***
// Purpose: carries alarm settings and running time to the comparator
// Assumes: all signals on one clock
// Notes: field order is seconds, minutes, hours, date, month, weekday
`timescale 1ns/1ps
interface rtca_cmp_if;
  import rtca_pkg::*;
  logic [7:0] alarm [RTCA_FIELDS];
  logic [7:0] cur [RTCA_FIELDS];
  logic match;
  logic any_en;
  modport cmp (input alarm, input cur, output match, output any_en);
  modport user (output alarm, output cur, input match, input any_en);
endinterface

// *** core/rtca_match.sv ***
// Purpose: compares running time against the enabled alarm fields
// Assumes: time fields in BCD, same encoding as the alarm values
// Notes: purely combinational
`timescale 1ns/1ps
module rtca_match
  import rtca_pkg::*;
(
  // comparison carrier
  rtca_cmp_if.cmp cmp_if
);
  logic [RTCA_FIELDS-1:0] hit;
  logic [RTCA_FIELDS-1:0] en;

  // a field counts when disabled or equal in its value bits
  function automatic logic field_hit(input logic [7:0] alm, input logic [7:0] cur);
    field_hit = !alm[RTCA_CMP_EN_BIT] || (alm[6:0] == cur[6:0]);
  endfunction

  // per-field enable and hit
  genvar g;
  generate
    for (g = 0; g < RTCA_FIELDS; g++) begin : g_field
      assign en[g] = cmp_if.alarm[g][RTCA_CMP_EN_BIT];
      assign hit[g] = field_hit(cmp_if.alarm[g], cmp_if.cur[g]);
    end
  endgenerate

  // no enabled field means never matching
  assign cmp_if.any_en = |en;
  assign cmp_if.match = cmp_if.any_en && (&hit);
endmodule

// *** core/rtc_alarm_match_unit.sv ***
// Purpose: alarm-0 registers, match event, status flag and interrupt
// Assumes: tick_in pulses one cycle once per second from same-clock logic,
//   and the cur_* time inputs already hold the new time in that cycle
// Notes: registers over AXI4-Lite; one write and one read in flight
//
// Register access over AXI4-Lite and the register offsets were decided locally.
`timescale 1ns/1ps
// Notes on behaviour
// - field bit 7 enables compare, rest BCD
// - disabled field accepts any current value
// - alarm enable bit 5 gates all events
// - single mode fires once on entering match
// - pulsed mode fires on every matching tick
// - flag set per trigger, clearing not needed
module rtc_alarm_match_unit
  import rtca_pkg::*;
(
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // timekeeping side
  input wire logic tick_in,
  input wire logic [7:0] cur_seconds_in,
  input wire logic [7:0] cur_minutes_in,
  input wire logic [7:0] cur_hours_in,
  input wire logic [7:0] cur_date_in,
  input wire logic [7:0] cur_month_in,
  input wire logic [7:0] cur_weekday_in,
  // write address channel
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [7:0] s_axi_awaddr_in,
  // write data channel
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  // write response channel
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  output logic [1:0] s_axi_bresp_out,
  // read address channel
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  input wire logic [7:0] s_axi_araddr_in,
  // read data channel
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  // event outputs
  output logic alarm_event_out,
  output logic irq_out
);
  // register state
  logic [7:0] alarm_r [RTCA_FIELDS];
  logic [7:0] ctrl_r;
  logic [7:0] status_r;
  logic [7:0] status_nxt;
  logic [7:0] mask_r;
  logic match_prev_r;
  logic evt_r;
  logic irq_r;

  // bus state
  logic awready_r;
  logic wready_r;
  logic aw_have_r;
  logic w_have_r;
  logic [7:0] waddr_r;
  logic [7:0] wdata_r;
  logic wstrb0_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic arready_r;
  logic rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;

  // byte address to register index, shared by read and write
  function automatic logic [3:0] reg_index(input logic [7:0] addr);
    if (addr > RTCA_OFS_MASK) begin
      reg_index = RTCA_IDX_NONE;
    end else begin
      reg_index = addr[5:2];
    end
  endfunction

  // comparator hookup
  rtca_cmp_if cmp_bus ();
  logic [7:0] cur_time [RTCA_FIELDS];
  assign cur_time[0] = cur_seconds_in;
  assign cur_time[1] = cur_minutes_in;
  assign cur_time[2] = cur_hours_in;
  assign cur_time[3] = cur_date_in;
  assign cur_time[4] = cur_month_in;
  assign cur_time[5] = cur_weekday_in;

  genvar g;
  generate
    for (g = 0; g < RTCA_FIELDS; g++) begin : g_bind
      assign cmp_bus.alarm[g] = alarm_r[g];
      assign cmp_bus.cur[g] = cur_time[g];
    end
  endgenerate

  rtca_match u_match (
    .cmp_if(cmp_bus.cmp)
  );

  // control bits and the event decision
  wire alm_en = ctrl_r[RTCA_ALM_EN_BIT];
  wire pulsed_repeat_select = ctrl_r[RTCA_PULSED_BIT];
  wire match_now = cmp_bus.match;
  // single mode needs a fresh match so one event per match window
  wire single_ok = !pulsed_repeat_select && !match_prev_r;
  wire fire = tick_in && alm_en && match_now && (pulsed_repeat_select || single_ok);

  // write path decoding
  wire aw_hs = s_axi_awvalid_in && awready_r;
  wire w_hs = s_axi_wvalid_in && wready_r;
  wire do_write = aw_have_r && w_have_r && !bvalid_r;
  wire [3:0] widx = reg_index(waddr_r);
  wire wr_ok = (widx != RTCA_IDX_NONE);
  wire wr_en = do_write && wr_ok && wstrb0_r;
  wire [7:0] w1c = (wr_en && widx == RTCA_IDX_STATUS) ? wdata_r : 8'h00;

  // read path decoding
  wire ar_hs = s_axi_arvalid_in && arready_r;
  wire [3:0] ridx = reg_index(s_axi_araddr_in);
  logic [7:0] rd_byte;
  always_comb begin
    rd_byte = 8'h00;
    if (ridx < RTCA_IDX_CTRL) begin
      rd_byte = alarm_r[ridx[2:0]];
    end else if (ridx == RTCA_IDX_CTRL) begin
      rd_byte = ctrl_r;
    end else if (ridx == RTCA_IDX_STATUS) begin
      rd_byte = status_r;
    end else if (ridx == RTCA_IDX_MASK) begin
      rd_byte = mask_r;
    end
  end

  // sticky flag: a trigger in the clearing cycle wins
  always_comb begin
    status_nxt = status_r & ~w1c;
    status_nxt[RTCA_FLAG_BIT] = fire || (status_r[RTCA_FLAG_BIT] && !w1c[RTCA_FLAG_BIT]);
  end

  // alarm field registers
  generate
    for (g = 0; g < RTCA_FIELDS; g++) begin : g_alarm
      always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
          alarm_r[g] <= RTCA_ALM_RST;
        end else if (wr_en && widx == 4'(g)) begin
          alarm_r[g] <= wdata_r;
        end
      end
    end
  endgenerate

  // control and mask registers
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ctrl_r <= RTCA_CTRL_RST;
      mask_r <= RTCA_MASK_RST;
    end else if (wr_en) begin
      if (widx == RTCA_IDX_CTRL) ctrl_r <= wdata_r;
      if (widx == RTCA_IDX_MASK) mask_r <= wdata_r;
    end
  end

  // event, status and interrupt
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      status_r <= RTCA_STATUS_RST;
      evt_r <= 1'b0;
      irq_r <= 1'b0;
      match_prev_r <= 1'b0;
    end else begin
      status_r <= status_nxt;
      evt_r <= fire;
      irq_r <= |(status_nxt & mask_r);
      if (tick_in) match_prev_r <= match_now;
    end
  end

  // write channels: each accepted once, in either order
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      awready_r <= 1'b1;
      wready_r <= 1'b1;
      aw_have_r <= 1'b0;
      w_have_r <= 1'b0;
      waddr_r <= 8'h00;
      wdata_r <= 8'h00;
      wstrb0_r <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r <= RTCA_RESP_OKAY;
    end else begin
      if (aw_hs) begin
        awready_r <= 1'b0;
        aw_have_r <= 1'b1;
        waddr_r <= s_axi_awaddr_in;
      end
      if (w_hs) begin
        wready_r <= 1'b0;
        w_have_r <= 1'b1;
        wdata_r <= s_axi_wdata_in[7:0];
        wstrb0_r <= s_axi_wstrb_in[0];
      end
      if (do_write) begin
        aw_have_r <= 1'b0;
        w_have_r <= 1'b0;
        bvalid_r <= 1'b1;
        bresp_r <= wr_ok ? RTCA_RESP_OKAY : RTCA_RESP_SLVERR;
      end
      if (bvalid_r && s_axi_bready_in) begin
        bvalid_r <= 1'b0;
        awready_r <= 1'b1;
        wready_r <= 1'b1;
      end
    end
  end

  // read channel: answer one cycle after the address
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      arready_r <= 1'b1;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h00000000;
      rresp_r <= RTCA_RESP_OKAY;
    end else if (ar_hs) begin
      arready_r <= 1'b0;
      rvalid_r <= 1'b1;
      rdata_r <= {24'h000000, rd_byte};
      rresp_r <= (ridx == RTCA_IDX_NONE) ? RTCA_RESP_SLVERR : RTCA_RESP_OKAY;
    end else if (rvalid_r && s_axi_rready_in) begin
      rvalid_r <= 1'b0;
      arready_r <= 1'b1;
    end
  end

  // outputs straight from flops
  assign s_axi_awready_out = awready_r;
  assign s_axi_wready_out = wready_r;
  assign s_axi_bvalid_out = bvalid_r;
  assign s_axi_bresp_out = bresp_r;
  assign s_axi_arready_out = arready_r;
  assign s_axi_rvalid_out = rvalid_r;
  assign s_axi_rdata_out = rdata_r;
  assign s_axi_rresp_out = rresp_r;
  assign alarm_event_out = evt_r;
  assign irq_out = irq_r;

  // independent match model for checking, built from raw fields
  logic [RTCA_FIELDS-1:0] chk_ok;
  logic [RTCA_FIELDS-1:0] chk_en;
  generate
    for (g = 0; g < RTCA_FIELDS; g++) begin : g_chk
      assign chk_en[g] = alarm_r[g][7];
      // any field with bit 7 clear is a wildcard, not only an all-zero one
      assign chk_ok[g] = !chk_en[g] || (alarm_r[g][6:0] == cur_time[g][6:0]);
    end
  endgenerate
  wire chk_match = (|chk_en) && (&chk_ok);

  // seconds enabled but wrong means no event
  property p_sec_mismatch;
    @(posedge clk_in) disable iff (!rst_n_in)
    (tick_in && alarm_r[0][7] && (alarm_r[0][6:0] != cur_seconds_in[6:0])) |=> !evt_r;
  endproperty
  a_sec_mismatch: assert property (p_sec_mismatch)
    else $error("event despite seconds mismatch");

  // disabled fields never block a pulsed match
  property p_disabled_field;
    @(posedge clk_in) disable iff (!rst_n_in)
    (tick_in && alm_en && pulsed_repeat_select && chk_match) |=> evt_r;
  endproperty
  a_disabled_field: assert property (p_disabled_field)
    else $error("disabled field blocked a match");

  // no events while alarm enable is clear
  property p_enable_gate;
    @(posedge clk_in) disable iff (!rst_n_in)
    (tick_in && !alm_en) |=> !evt_r && !$rose(status_r[0]);
  endproperty
  a_enable_gate: assert property (p_enable_gate)
    else $error("event with alarm disabled");

  // single mode: no second event while still matching
  property p_single_once;
    @(posedge clk_in) disable iff (!rst_n_in)
    (tick_in && !pulsed_repeat_select && match_prev_r) |=> !evt_r;
  endproperty
  a_single_once: assert property (p_single_once)
    else $error("repeated event in single mode");

  // single mode: fresh match fires within one cycle
  property p_single_fire;
    @(posedge clk_in) disable iff (!rst_n_in)
    (tick_in && alm_en && !pulsed_repeat_select && !match_prev_r && chk_match)
      |=> evt_r ##0 status_r[0];
  endproperty
  a_single_fire: assert property (p_single_fire)
    else $error("single alarm missed");

  // pulsed mode: consecutive matching ticks each fire
  property p_pulsed_repeat;
    @(posedge clk_in) disable iff (!rst_n_in)
    (tick_in && alm_en && pulsed_repeat_select && match_now && match_prev_r) |=> evt_r;
  endproperty
  a_pulsed_repeat: assert property (p_pulsed_repeat)
    else $error("pulsed alarm did not repeat");

  // every event leaves the flag set, even during a clear
  property p_flag_set;
    @(posedge clk_in) disable iff (!rst_n_in)
    evt_r |-> status_r[0];
  endproperty
  a_flag_set: assert property (p_flag_set)
    else $error("event without status flag");

  // all fields disabled: never an event
  property p_none_enabled;
    @(posedge clk_in) disable iff (!rst_n_in)
    (chk_en == '0) |=> !evt_r;
  endproperty
  a_none_enabled: assert property (p_none_enabled)
    else $error("event with no field enabled");

  // interrupt changes with the flag in the same cycle, but with a mask change one cycle later
  property p_irq_follow;
    @(posedge clk_in) disable iff (!rst_n_in)
    ##1 (irq_r == |(status_r & $past(mask_r)));
  endproperty
  a_irq_follow: assert property (p_irq_follow)
    else $error("interrupt level wrong");

  // read answer exactly one cycle after address
  property p_read_latency;
    @(posedge clk_in) disable iff (!rst_n_in)
    ar_hs |=> rvalid_r;
  endproperty
  a_read_latency: assert property (p_read_latency)
    else $error("read answer late");
endmodule

// *** verif/test_rtc_alarm_match_unit.sv ***
// Purpose: self-checking bench for the alarm-0 match unit
// Assumes: AXI4-Lite master tasks enter and leave just after a rising edge
// Notes: time values are BCD, packed {weekday, month, date, hours, minutes, seconds}
`timescale 1ns/1ps
module test_rtc_alarm_match_unit;
  import rtca_pkg::*;
  // clock, reset and stimulus
  logic clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic tick_in = 1'b0;
  logic [47:0] cur_t = 48'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hF;
  logic awready, wready, bvalid, arready, rvalid, alarm_event_out, irq_out;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [31:0] rd;
  logic [1:0] rsp;
  int n_fail = 0;
  int n_checks = 0;

  rtc_alarm_match_unit dut (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .tick_in(tick_in),
    .cur_seconds_in(cur_t[7:0]), .cur_minutes_in(cur_t[15:8]), .cur_hours_in(cur_t[23:16]),
    .cur_date_in(cur_t[31:24]), .cur_month_in(cur_t[39:32]), .cur_weekday_in(cur_t[47:40]),
    .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready), .s_axi_awaddr_in(awaddr),
    .s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready), .s_axi_wdata_in(wdata),
    .s_axi_wstrb_in(wstrb), .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
    .s_axi_bresp_out(bresp), .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready),
    .s_axi_araddr_in(araddr), .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready),
    .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp),
    .alarm_event_out(alarm_event_out), .irq_out(irq_out)
  );

  // 20 MHz clock
  initial begin
    forever #25 clk_in = ~clk_in;
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic results();
    $display("checks=%0d failures=%0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // write: address and data offered together, each released when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    bit aw_done, w_done;
    aw_done = 0;
    w_done = 0;
    r = 2'h3;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_done && w_done)) begin
      @(posedge clk_in);
      if (!aw_done && awready === 1'b1) begin
        aw_done = 1;
        awvalid <= 1'b0;
      end
      if (!w_done && wready === 1'b1) begin
        w_done = 1;
        wvalid <= 1'b0;
      end
    end
    // the answer may already be pending; sample from the next edge on
    do begin
      @(posedge clk_in);
    end while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
    // idle edge, so a following call never redrives a released signal in one step
    @(posedge clk_in);
  endtask

  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk_in);
      if (arready === 1'b1) begin
        arvalid <= 1'b0;
      end
    end while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    // idle edge before the next call raises rready again
    @(posedge clk_in);
  endtask

  task automatic wr_ok(input logic [7:0] a, input logic [31:0] d);
    wr(a, d, rsp);
    check(rsp, RTCA_RESP_OKAY);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    rd_reg(a, rd, rsp);
    check(rd, exp);
  endtask

  // one tick with the given time; count event pulses over the following edges
  task automatic tick_at(input logic [47:0] t, input int exp_events);
    int cnt;
    cnt = 0;
    cur_t <= t;
    tick_in <= 1'b1;
    @(posedge clk_in);
    tick_in <= 1'b0;
    repeat (3) begin
      @(posedge clk_in);
      if (alarm_event_out === 1'b1) begin
        cnt++;
      end
    end
    check(cnt, exp_events);
  endtask

  task automatic set_alarm(input logic [47:0] a);
    for (int i = 0; i < 6; i++) begin
      wr_ok(8'(4 * i), {24'h0, a[8*i +: 8]});
    end
  endtask

  // watchdog: the whole sequence needs well under 5000 cycles
  initial begin
    repeat (20000) @(posedge clk_in);
    n_fail++;
    results();
  end

  initial begin
    repeat (12) @(posedge clk_in);
    rst_n_in <= 1'b1;
    @(posedge clk_in);
    // reset values of every register, then an unmapped read
    for (int i = 0; i <= 8; i++) begin
      rd_chk(8'(4 * i), 32'h0);
    end
    rd_reg(8'h24, rd, rsp);
    check(rsp, RTCA_RESP_SLVERR);
    check(rd, 32'h0);
    // upper bits ignored, masked strobe leaves value unchanged
    wr_ok(RTCA_OFS_ALM_SEC, 32'hABCD_12B5);
    rd_chk(RTCA_OFS_ALM_SEC, 32'h0000_00B5);
    wstrb <= 4'h0;
    wr_ok(RTCA_OFS_ALM_SEC, 32'h0000_0011);
    wstrb <= 4'hF;
    rd_chk(RTCA_OFS_ALM_SEC, 32'h0000_00B5);
    wr(8'h28, 32'h1, rsp);
    check(rsp, RTCA_RESP_SLVERR);
    // single event: 11:30 on day 1 of month 1, seconds and weekday ignored
    set_alarm(48'h00_81_81_91_B0_00);
    wr_ok(RTCA_OFS_MASK, 32'h1);
    tick_at(48'h03_01_01_11_29_59, 0);
    tick_at(48'h03_01_01_11_30_00, 0);
    wr_ok(RTCA_OFS_INT_CTRL, 32'h20);
    rd_chk(RTCA_OFS_INT_CTRL, 32'h20);
    tick_at(48'h05_01_01_11_30_01, 0);
    tick_at(48'h05_01_01_11_30_02, 0);
    tick_at(48'h05_01_01_11_29_59, 0);
    tick_at(48'h05_01_01_11_31_00, 0);
    tick_at(48'h06_01_01_11_30_00, 1);
    check(irq_out, 1'b1);
    rd_chk(RTCA_OFS_STATUS, 32'h1);
    tick_at(48'h06_01_01_11_30_01, 0);
    wr_ok(RTCA_OFS_STATUS, 32'h1);
    rd_chk(RTCA_OFS_STATUS, 32'h0);
    @(posedge clk_in);
    check(irq_out, 1'b0);
    // a miss first, so an ignored field would show as a fresh match
    tick_at(48'h06_01_01_11_29_59, 0);
    // wrong hour, date, month each refuse a match
    tick_at(48'h06_01_01_12_30_00, 0);
    tick_at(48'h06_01_02_11_30_00, 0);
    tick_at(48'h06_02_01_11_30_00, 0);
    // pulsed mode, seconds 30, flag never cleared between pulses
    set_alarm(48'h00_00_00_00_00_B0);
    wr_ok(RTCA_OFS_INT_CTRL, 32'hA0);
    tick_at(48'h01_02_03_04_05_30, 1);
    tick_at(48'h01_02_03_04_05_31, 0);
    tick_at(48'h01_02_03_04_06_30, 1);
    tick_at(48'h01_02_03_04_07_30, 1);
    rd_chk(RTCA_OFS_STATUS, 32'h1);
    // mask off: flag still set, no interrupt
    wr_ok(RTCA_OFS_MASK, 32'h0);
    @(posedge clk_in);
    check(irq_out, 1'b0);
    wr_ok(RTCA_OFS_MASK, 32'h1);
    @(posedge clk_in);
    check(irq_out, 1'b1);
    wr_ok(RTCA_OFS_STATUS, 32'h1);
    // alarm enable cleared in pulsed mode
    wr_ok(RTCA_OFS_INT_CTRL, 32'h80);
    tick_at(48'h01_02_03_04_08_30, 0);
    // every field disabled never matches
    wr_ok(RTCA_OFS_INT_CTRL, 32'hA0);
    set_alarm(48'h0);
    tick_at(48'h00_00_00_00_00_00, 0);
    tick_at(48'h01_02_03_04_05_30, 0);
    rd_chk(RTCA_OFS_STATUS, 32'h0);
    check(irq_out, 1'b0);
    results();
  end
endmodule
